/* File: logic/swd_pkg.sv */
// shared constants and types for the switch detect serial link
package swd_pkg;
	// ---------------------------------------------------------------
	// frame layout
	// ---------------------------------------------------------------
	localparam int SWD_WORD_BITS = 24;
	localparam int SWD_NUM_DUAL = 8;
	localparam int SWD_NUM_GND = 14;
	localparam int SWD_NUM_SW = SWD_NUM_DUAL + SWD_NUM_GND;
	// status word: int flag on top, thermal flag next, switches below
	localparam int SWD_POS_INT = 23;
	localparam int SWD_POS_THERM = 22;
	localparam int SWD_POS_SW = 0;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [SWD_NUM_DUAL-1:0] SWD_RST_POL = 8'hFF;
	localparam logic [SWD_NUM_SW-1:0] SWD_RST_IEN = 22'h3FFFFF;
	localparam logic [SWD_WORD_BITS-1:0] SWD_RST_WORD = 24'h000000;
	// host serial clock divider: half period in clk cycles
	localparam int SWD_HALF_CYCLES = 20;
	// host timing guards in clk cycles
	localparam int SWD_LEAD_CYCLES = 20;
	localparam int SWD_LAG_CYCLES = 10;
	typedef enum logic [1:0] {
		SWD_IDLE = 2'b00,
		SWD_LEAD = 2'b01,
		SWD_SHIFT = 2'b10,
		SWD_LAG = 2'b11
	} swd_host_state_t;
endpackage

/* File: logic/swd_if.sv */
// interface joining the switch detect device and its host
`timescale 1ns/1ps
interface swd_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe_n;
	logic int_n_out;
	logic int_n_oe_n;
	logic int_n_in;
	logic wake_n_out;
	logic wake_n_oe_n;
	logic wake_n_in;
	// resolved wire levels; open drain lines pull up when released
	assign int_n_in = int_n_oe_n ? 1'b1 : int_n_out;
	assign wake_n_in = wake_n_oe_n ? 1'b1 : wake_n_out;
	modport dev (
		input cs_n,
		input sclk,
		input si,
		output so,
		output so_oe_n,
		output int_n_out,
		output int_n_oe_n,
		input int_n_in,
		output wake_n_out,
		output wake_n_oe_n,
		input wake_n_in
	);
	modport host (
		output cs_n,
		output sclk,
		output si,
		input so,
		input so_oe_n,
		input int_n_in,
		input wake_n_in
	);
endinterface

/* File: logic/swd_dev.sv */
// device end: serial slave, interrupt and wake pin logic
`timescale 1ns/1ps
// Contract
// RULE_01: cs fall enables so, captures int and switches
// RULE_02: cs rise tri-states so
// RULE_03: cs rise releases int unless new change
// RULE_04: command applied only at cs rise
// RULE_05: host moves cs only with sclk low
// RULE_06: cs fall wakes sleep with logic supply
// RULE_07: si sampled on sclk falling edge
// RULE_08: so shifts on rise, host samples fall
// RULE_09: host should idle sclk low
// RULE_10: cs high ignores sclk and si
// RULE_11: command word is 24 bits
// RULE_12: open reads 0, closed reads 1
// RULE_13: first rise shows bit 24, then lower
// RULE_14: msb first both directions
// RULE_15: enabled input change pulls int low; code masks change in sleep mode
// RULE_16: int flag captured at cs fall
// RULE_17: int line fall wakes sleep device
// RULE_18: wake pin low normal, high sleep
// RULE_19: wake fall wakes, int must be high; code skips the int check when logic supply is off
// RULE_20: cs and int wake need logic supply
// RULE_21: dual inputs follow polarity setting
// RULE_22: ground inputs closed below reference
// RULE_23: every reply carries status and flags
// RULE_24: change is current versus captured state
module swd_dev
	import swd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	swd_if.dev link,
	input wire logic [SWD_NUM_DUAL-1:0] dual_polarity_inputs,
	input wire logic [SWD_NUM_GND-1:0] ground_only_inputs,
	input wire logic logic_supply_on,
	input wire logic thermal_flag,
	input wire logic sleep_req,
	output logic sleep_mode,
	output logic [SWD_WORD_BITS-1:0] cmd_word,
	output logic cmd_valid,
	output logic [SWD_NUM_DUAL-1:0] polarity_sel,
	output logic [SWD_NUM_SW-1:0] int_enable
);
	// ---------------------------------------------------------------
	// edge detection on pins
	// ---------------------------------------------------------------
	logic cs_q, sclk_q, int_q, wake_q;
	logic cs_fall, cs_rise, sclk_rise, sclk_fall, int_fall, wake_fall;
	// pins are synchronous to clk, so one stage is enough for edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_q <= 1'b1;
			sclk_q <= 1'b0;
			int_q <= 1'b1;
			wake_q <= 1'b0; // wake pin sits low in normal mode, so no false edge
		end else begin
			cs_q <= link.cs_n;
			sclk_q <= link.sclk;
			int_q <= link.int_n_in;
			wake_q <= link.wake_n_in;
		end
	end
	assign cs_fall = cs_q & ~link.cs_n;
	assign cs_rise = ~cs_q & link.cs_n;
	// sclk edges only count while selected
	assign sclk_rise = ~link.cs_n & ~sclk_q & link.sclk; // see RULE_10
	assign sclk_fall = ~link.cs_n & sclk_q & ~link.sclk; // see RULE_10
	assign int_fall = int_q & ~link.int_n_in;
	assign wake_fall = wake_q & ~link.wake_n_in;

	// ---------------------------------------------------------------
	// switch qualification
	// ---------------------------------------------------------------
	logic [SWD_NUM_SW-1:0] sw_closed;
	genvar gi;
	generate
		for (gi = 0; gi < SWD_NUM_DUAL; gi++) begin : g_dual
			// input high means above reference; polarity 1 is battery
			assign sw_closed[gi] = polarity_sel[gi] ? dual_polarity_inputs[gi]
				: ~dual_polarity_inputs[gi]; // see RULE_21
		end
		for (gi = 0; gi < SWD_NUM_GND; gi++) begin : g_gnd
			assign sw_closed[SWD_NUM_DUAL+gi] = ~ground_only_inputs[gi]; // see RULE_22
		end
	endgenerate

	// ---------------------------------------------------------------
	// mode: normal or sleep
	// ---------------------------------------------------------------
	logic wake_evt;
	always_comb begin
		wake_evt = (cs_fall & logic_supply_on) // see RULE_06 see RULE_20
			| (int_fall & link.wake_n_in & logic_supply_on) // see RULE_17
			| (wake_fall & (link.int_n_in | ~logic_supply_on)); // see RULE_19
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_mode <= 1'b0;
		end else if (sleep_mode && wake_evt) begin
			sleep_mode <= 1'b0;
		end else if (!sleep_mode && sleep_req && link.cs_n) begin
			sleep_mode <= 1'b1;
		end
	end
	// wake pin low in normal mode, released in sleep
	assign link.wake_n_out = 1'b0;
	assign link.wake_n_oe_n = sleep_mode; // see RULE_18

	// ---------------------------------------------------------------
	// change detection and interrupt
	// ---------------------------------------------------------------
	logic [SWD_NUM_SW-1:0] ref_q;
	logic change, int_act_q, chg_in_frame_q;
	// compare with the last state captured; held still during a frame
	assign change = ~sleep_mode & |((sw_closed ^ ref_q) & int_enable); // see RULE_24 see RULE_15
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_q <= '0;
		end else if (cs_fall || (link.cs_n && change)) begin
			ref_q <= sw_closed;
		end
	end
	// changes seen while selected keep int asserted past cs rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chg_in_frame_q <= 1'b0;
		end else if (!link.cs_n && change) begin
			chg_in_frame_q <= 1'b1; // set beats the select clear
		end else if (cs_fall) begin
			chg_in_frame_q <= 1'b0;
		end
	end
	// set beats clear so a change at cs rise is not lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_act_q <= 1'b0;
		end else if (change) begin
			int_act_q <= 1'b1; // see RULE_15
		end else if (cs_rise && !chg_in_frame_q) begin
			int_act_q <= 1'b0; // see RULE_03
		end
	end
	assign link.int_n_out = 1'b0;
	assign link.int_n_oe_n = ~int_act_q;

	// ---------------------------------------------------------------
	// shift registers
	// ---------------------------------------------------------------
	logic [SWD_WORD_BITS-1:0] tx_q, rx_q;
	logic [4:0] bit_cnt_q;
	logic so_q, so_en_q;
	// status word captured at select; own int state only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= SWD_RST_WORD;
			so_q <= 1'b0;
		end else if (cs_fall) begin
			tx_q <= '0;
			tx_q[SWD_POS_INT] <= int_act_q; // see RULE_01 see RULE_16
			tx_q[SWD_POS_THERM] <= thermal_flag; // see RULE_23
			tx_q[SWD_POS_SW +: SWD_NUM_SW] <= sw_closed; // see RULE_01 see RULE_12
		end else if (sclk_rise) begin
			so_q <= tx_q[SWD_WORD_BITS-1]; // see RULE_13 see RULE_08
			tx_q <= {tx_q[SWD_WORD_BITS-2:0], 1'b0}; // see RULE_14
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			so_en_q <= 1'b0;
		end else if (cs_fall) begin
			so_en_q <= 1'b1; // see RULE_01
		end else if (cs_rise) begin
			so_en_q <= 1'b0; // see RULE_02
		end
	end
	assign link.so = so_q;
	assign link.so_oe_n = ~so_en_q;
	// input bits enter lsb and climb, so the first lands on top
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_q <= '0;
			bit_cnt_q <= '0;
		end else if (cs_fall) begin
			bit_cnt_q <= '0;
		end else if (sclk_fall) begin
			rx_q <= {rx_q[SWD_WORD_BITS-2:0], link.si}; // see RULE_07 see RULE_14
			if (bit_cnt_q != 5'(SWD_WORD_BITS)) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// command apply
	// ---------------------------------------------------------------
	// short frames are dropped; long ones keep the last 24 bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_word <= '0;
			cmd_valid <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			if (cs_rise && bit_cnt_q == 5'(SWD_WORD_BITS)) begin
				cmd_word <= rx_q; // see RULE_04 see RULE_11
				cmd_valid <= 1'b1;
			end
		end
	end
	// small decode: 0x01 sets polarity, 0x02/0x03 set interrupt enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			polarity_sel <= SWD_RST_POL;
			int_enable <= SWD_RST_IEN;
		end else if (cs_rise && bit_cnt_q == 5'(SWD_WORD_BITS)) begin
			case (rx_q[23:16])
				8'h01: polarity_sel <= rx_q[7:0]; // see RULE_04
				8'h02: int_enable[7:0] <= rx_q[7:0];
				8'h03: int_enable[21:8] <= rx_q[13:0];
				default: ;
			endcase
		end
	end
endmodule // swd_dev

/* File: logic/swd_host.sv */
// host end: serial master driving frames to the device
`timescale 1ns/1ps
module swd_host
	import swd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	swd_if.host link,
	input wire logic start,
	input wire logic [SWD_WORD_BITS-1:0] tx_word,
	output logic busy,
	output logic [SWD_WORD_BITS-1:0] rx_word,
	output logic rx_valid,
	output logic irq,
	output logic dev_awake
);
	// ---------------------------------------------------------------
	// state and counters
	// ---------------------------------------------------------------
	swd_host_state_t st_q;
	logic [7:0] cnt_q;
	logic [4:0] bits_q;
	logic [SWD_WORD_BITS-1:0] sh_q, in_q;
	logic cs_q, sclk_q;
	assign link.cs_n = cs_q;
	assign link.sclk = sclk_q;
	assign link.si = sh_q[SWD_WORD_BITS-1]; // see RULE_14
	assign busy = (st_q != SWD_IDLE);
	assign irq = ~link.int_n_in;
	assign dev_awake = ~link.wake_n_in;
	// one fsm; sclk only moves at the end of lead and inside shift, so cs edges see it low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= SWD_IDLE;
			cnt_q <= '0;
			bits_q <= '0;
			sh_q <= '0;
			in_q <= '0;
			cs_q <= 1'b1;
			sclk_q <= 1'b0; // see RULE_09
			rx_word <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			case (st_q)
				SWD_IDLE: begin
					if (start) begin
						sh_q <= tx_word;
						cs_q <= 1'b0; // see RULE_05
						cnt_q <= '0;
						bits_q <= '0;
						st_q <= SWD_LEAD;
					end
				end
				SWD_LEAD: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == 8'(SWD_LEAD_CYCLES - 1)) begin
						cnt_q <= '0;
						sclk_q <= 1'b1;
						st_q <= SWD_SHIFT;
					end
				end
				SWD_SHIFT: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == 8'(SWD_HALF_CYCLES - 1)) begin
						cnt_q <= '0;
						sclk_q <= ~sclk_q;
						if (sclk_q) begin
							// falling edge: sample so, si holds past the device's late sample
							in_q <= {in_q[SWD_WORD_BITS-2:0], link.so}; // see RULE_08
							bits_q <= bits_q + 5'h01;
							if (bits_q == 5'(SWD_WORD_BITS - 1)) begin
								st_q <= SWD_LAG; // see RULE_11
							end
						end else begin
							// rising edge: next si bit, half a period before its fall
							sh_q <= {sh_q[SWD_WORD_BITS-2:0], 1'b0}; // see RULE_14
						end
					end
				end
				SWD_LAG: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == 8'(SWD_LAG_CYCLES - 1)) begin
						cs_q <= 1'b1; // see RULE_05
						rx_word <= in_q;
						rx_valid <= 1'b1;
						st_q <= SWD_IDLE;
					end
				end
				default: st_q <= SWD_IDLE;
			endcase
		end
	end
endmodule // swd_host

/* File: bench/swd_props.sv */
// assertions on the switch detect serial link
`timescale 1ns/1ps
module swd_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic so,
	input wire logic so_oe_n,
	input wire logic int_n_oe_n
);
	// ------------------------------
	// helper logic
	// ------------------------------
	logic sclk_q;
	logic [5:0] falls_q;
	// falls counted per frame, cleared while deselected
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			falls_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			if (cs_n)
				falls_q <= 6'h00;
			else if (sclk_q && !sclk)
				falls_q <= falls_q + 6'h01;
		end
	end
	// ------------------------------
	// properties
	// ------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_so_on;
		$fell(cs_n) |-> ##[1:2] !so_oe_n;
	endproperty
	property p_so_off;
		$rose(cs_n) |-> ##[1:2] so_oe_n;
	endproperty
	property p_so_hiz;
		cs_n [*3] |-> so_oe_n;
	endproperty
	// output may only move after a serial clock rise
	property p_so_shift;
		!so_oe_n && $past(!so_oe_n) && $changed(so) |-> $past(sclk);
	endproperty
	property p_int_rel;
		$rose(int_n_oe_n) |-> cs_n && (!$past(cs_n, 2) || !$past(cs_n, 3));
	endproperty
	property p_cs_move;
		$changed(cs_n) |-> !sclk && !$past(sclk);
	endproperty
	property p_idle_low;
		cs_n && $past(cs_n) |-> !sclk;
	endproperty
	property p_count;
		$rose(cs_n) |-> falls_q == 6'h18;
	endproperty
	a_so_on: assert property (p_so_on) else $error("so not enabled after select");
	a_so_off: assert property (p_so_off) else $error("so not released after deselect");
	a_so_hiz: assert property (p_so_hiz) else $error("so driven while deselected");
	a_so_shift: assert property (p_so_shift) else $error("so moved without clock rise");
	a_int_rel: assert property (p_int_rel) else $error("int released outside deselect");
	a_cs_move: assert property (p_cs_move) else $error("select moved with clock high");
	a_idle_low: assert property (p_idle_low) else $error("clock not idle low");
	a_count: assert property (p_count) else $error("frame not 24 clocks");
	c_select: cover property ($fell(cs_n));
	c_int: cover property ($fell(int_n_oe_n));
	c_int_held: cover property ($rose(cs_n) && !int_n_oe_n);
endmodule // swd_props

/* File: bench/swd_tb_top.sv */
// self-checking bench joining device and host ends
`timescale 1ns/1ps
module swd_tb_top
	import swd_pkg::*;
;
	logic clk;
	logic rst_n;
	logic [7:0] dual;
	logic [13:0] gnd;
	logic supply;
	logic therm;
	logic sleep_req;
	logic start;
	logic [23:0] tx_word;
	logic sleep_mode;
	logic [23:0] cmd_word;
	logic cmd_valid;
	logic [7:0] pol_sel;
	logic [21:0] ien;
	logic busy;
	logic [23:0] rx_word;
	logic rx_valid;
	logic irq;
	logic awake;
	int n_errors;
	int compares;
	int cycles;
	int i;
	logic [31:0] seed;
	logic [7:0] pol;
	logic [21:0] old_cl;
	logic exp_irq;
	swd_if link ();
	swd_dev swd_dev_i (.clk(clk), .rst_n(rst_n), .link(link), .dual_polarity_inputs(dual),
		.ground_only_inputs(gnd), .logic_supply_on(supply), .thermal_flag(therm), .sleep_req(sleep_req),
		.sleep_mode(sleep_mode), .cmd_word(cmd_word), .cmd_valid(cmd_valid), .polarity_sel(pol_sel),
		.int_enable(ien));
	swd_host swd_host_i (.clk(clk), .rst_n(rst_n), .link(link), .start(start), .tx_word(tx_word),
		.busy(busy), .rx_word(rx_word), .rx_valid(rx_valid), .irq(irq), .dev_awake(awake));
	swd_props swd_props_i (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk), .so(link.so),
		.so_oe_n(link.so_oe_n), .int_n_oe_n(link.int_n_oe_n));
	// ------------------------------
	// helpers
	// ------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// closed reads 1: battery polarity follows the level, ground inverts it
	function logic [21:0] closed(logic [7:0] d, logic [13:0] g, logic [7:0] p);
		return {~g, ~(d ^ p)};
	endfunction
	task check(string name, logic [23:0] seen, logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one whole frame through the host, bounded wait for its end
	task frame(logic [23:0] w);
		int k;
		@(negedge clk);
		start = 1'b1;
		tx_word = w;
		@(negedge clk);
		start = 1'b0;
		check("busy", 24'(busy), 24'h000001);
		k = 0;
		while (rx_valid !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (k == 3000)
			n_errors++;
		@(negedge clk);
		check("frame end", 24'({busy, cmd_valid}), 24'h000001);
		repeat (3) @(negedge clk);
	endtask
	task end_of_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ------------------------------
	// clock and watchdog
	// ------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// about 21 frames of 1000 cycles; ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_errors++;
			end_of_test();
		end
	end
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		{n_errors, compares, cycles} = {32'h0, 32'h0, 32'h0};
		seed = 32'h000035C0;
		rst_n = 1'b0;
		{dual, gnd, therm, sleep_req, start, tx_word} = {8'h00, 14'h3FFF, 3'h0, 24'h000000};
		supply = 1'b1;
		pol = 8'hFF;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check("idle", 24'({link.so_oe_n, awake, irq}), 24'h000006);
		check("ien reset", {2'b00, ien}, {2'b00, SWD_RST_IEN});
		check("pol reset", 24'(pol_sel), 24'(SWD_RST_POL));
		old_cl = closed(dual, gnd, pol);
		for (i = 0; i < 7; i++) begin
			frame(24'h000000);
			check("irq cleared", 24'(irq), 24'h000000);
			seed = rnd();
			if (i != 0)
				{therm, gnd, dual} = seed[22:0];
			repeat (8) @(negedge clk);
			exp_irq = closed(dual, gnd, pol) != old_cl;
			check("irq raised", 24'(irq), 24'(exp_irq));
			seed = rnd();
			frame({16'h0100, seed[7:0]});
			check("status", rx_word, {exp_irq, therm, closed(dual, gnd, pol)});
			check("command", cmd_word, {16'h0100, seed[7:0]});
			pol = seed[7:0];
			check("polarity", 24'(pol_sel), 24'(pol));
			old_cl = closed(dual, gnd, pol);
		end
		// masked inputs must not interrupt
		frame(24'h020000);
		frame(24'h000000);
		dual = ~dual;
		repeat (8) @(negedge clk);
		check("masked", {1'b0, ien, irq}, 24'h7FFE00);
		frame(24'h0200FF);
		// change while selected keeps the interrupt up
		fork
			frame(24'h000000);
			begin
				repeat (300) @(negedge clk);
				gnd = ~gnd;
			end
		join
		check("int held", 24'(irq), 24'h000001);
		frame(24'h000000);
		supply = 1'b0;
		sleep_req = 1'b1;
		repeat (8) @(negedge clk);
		check("sleep", 24'({sleep_mode, awake}), 24'h000002);
		sleep_req = 1'b0;
		frame(24'h000000);
		check("no supply wake", 24'(sleep_mode), 24'h000001);
		supply = 1'b1;
		frame(24'h000000);
		check("select wake", 24'({sleep_mode, awake}), 24'h000001);
		end_of_test();
	end
endmodule // swd_tb_top
